/* core/hsil_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "hsil_regs.vh"
// Operation
// - Frame start byte encodes type, repeat, priority
// - Ack byte forwarded with bits 5,4,1,0 cleared
// - Confirmation low bits 0001011, bit7 outcome
// - State byte: five flags over 111
// - Frame status byte: errors, 1,res,0,1,1
// - Config byte: 0, five features, 01
// - Data bytes pass; acks only when monitoring
// - Reset request reinitialises; indicate on Normal
// - Poll-state collision sets slave collision flag
// - Corrupted host byte sets receive error
// - Dominant readback mismatch sets transmit error
// - Bad sequence and thermal set flags
// - Busy plus auto-ack answers own address busy
// - Host ack request leaves busy mode
// - Quit-busy restores positive acks when applicable
// - Monitor forwards everything, exits only on reset
// - Auto-ack: own/group only; negative on error, busy if own in busy mode, else positive
// - First set-address enables auto-ack too
// - Auto-ack enable confirmed by config byte
// - Set-address takes effect at bus idle
// - Auto-ack stays on until reset request
// - Set-address dummy byte ignored entirely
module hsil_core (
  input  wire       clk_i,            // System clock
  input  wire       arst_n_i,         // Async reset, low
  input  wire [7:0] host_byte_i,      // Byte from host link
  input  wire       host_valid_i,     // Host byte strobe
  input  wire       host_corrupt_i,   // Parity/stop/frame check failed
  input  wire       host_ack_req_i,   // Host acknowledge request seen
  input  wire       seq_error_i,      // Invalid command sequence
  input  wire       poll_collision_i, // Collision during poll slot
  input  wire       tx_mismatch_i,    // Sent 0, read 1
  input  wire       thermal_i,        // Thermal warning level
  input  wire       normal_entry_i,   // Entered Normal state
  input  wire       bus_idle_i,       // Bus idle level
  input  wire [7:0] bus_byte_i,       // Byte from bus
  input  wire [1:0] bus_kind_i,       // Data, ack or frame status
  input  wire       bus_valid_i,      // Bus byte strobe
  input  wire       frame_start_i,    // Frame start event
  input  wire       frame_ext_i,      // Extended frame
  input  wire       frame_norep_i,    // Not repeated
  input  wire [1:0] frame_prio_i,     // Priority bits
  input  wire       con_valid_i,      // Transmit outcome event
  input  wire       con_pos_i,        // Outcome positive
  input  wire       dst_match_i,      // Dest equals own address
  input  wire       dst_group_i,      // Dest is group address
  input  wire       ack_slot_i,       // Time to answer frame
  input  wire       rx_err_i,         // Error in frame reception
  input  wire       auto_poll_i,      // Auto-polling feature on
  input  wire       crc_on_i,         // CRC feature on
  input  wire       marker_on_i,      // Marker frame-end on
  input  wire       ind_ready_i,      // Host link takes byte
  output reg  [7:0] ind_byte_o,       // Byte to host
  output reg        ind_valid_o,      // Byte to host valid
  output reg  [1:0] bus_ack_o,        // 0 none,1 pos,2 neg,3 busy
  output reg        bus_ack_valid_o,  // Ack answer strobe
  output reg        auto_ack_active_o,// Auto-ack state
  output reg        busy_mode_o,      // Busy mode state
  output reg        monitor_o,        // Bus monitoring state
  output reg [15:0] phys_addr_o,      // Stored physical address
  output reg        overflow_o        // Indication dropped
);
  // =====================================
  // State
  // Parser states for the multi-byte set-address command
  // Single-byte commands never leave the opcode state
  // Reset opcode is only decoded in the opcode state, so an
  // address or dummy byte equal to it is never taken as reset
  localparam S_CMD = 2'h0;            // Await opcode
  localparam S_AH  = 2'h1;            // Address high
  localparam S_AL  = 2'h2;            // Address low
  localparam S_DUM = 2'h3;            // Dummy byte
  reg  [1:0]  state;                  // Command parser state
  reg  [7:0]  addr_hi;                // Pending high byte
  reg  [15:0] pend_addr;              // Address awaiting idle
  reg         pend_valid;             // Address pending
  reg         slave_collision_flag;   // Flags
  reg         receive_error_flag;
  reg         transmit_error_flag;
  reg         sequence_error_flag;
  reg         thermal_warning_flag;
  reg  [7:0]  enq_byte;               // Byte to queue
  reg         enq_valid;              // Queue request
  wire        fifo_wready;            // Queue not full
  wire [7:0]  fifo_rdata;             // Queue head
  wire        fifo_rvalid;            // Queue not empty
  wire        is_cmd = host_valid_i && (state == S_CMD);
  wire        do_reset = is_cmd && (host_byte_i == `HSIL_CMD_RESET);

  // =====================================
  // Helpers
  // Config byte built from current features
  // Feature bits other than busy and auto-ack come from outside levels;
  // this block only owns the busy and auto-ack states
  function [7:0] cfg_byte;
    input b;
    input aa;
    input ap;
    input c;
    input m;
    begin
      cfg_byte = {1'b0, b, aa, ap, c, m, `HSIL_CFG_LOW};
    end
  endfunction

  // =====================================
  // Indication byte selection, one per cycle by priority
  // Lower-priority events in the same cycle are rare; dropped ones do not flag overflow
  // Trade-off: a fixed priority keeps the queue single-ported,
  // at the cost of losing a colliding lower-priority event
  // State request first, so every request gets its one answer unless the queue is full
  // Ack bytes are filtered here, before the queue, so a
  // filtered ack never occupies a queue slot
  always @*
  begin
    enq_byte  = 8'h00;
    enq_valid = 1'b0;
    if (is_cmd && host_byte_i == `HSIL_CMD_STATE)
    begin
      enq_valid = 1'b1;
      enq_byte  = {slave_collision_flag, receive_error_flag, transmit_error_flag,
                   sequence_error_flag, thermal_warning_flag, `HSIL_STATE_LOW};
    end
    else if (normal_entry_i)
    begin
      enq_valid = 1'b1;
      enq_byte  = `HSIL_IND_RESET;
    end
    else if (pend_valid && bus_idle_i && !auto_ack_active_o)
    begin
      enq_valid = 1'b1;
      enq_byte  = cfg_byte(busy_mode_o, 1'b1, auto_poll_i, crc_on_i, marker_on_i);
    end
    else if (con_valid_i)
    begin
      enq_valid = 1'b1;
      enq_byte  = {con_pos_i, `HSIL_CON_LOW};
    end
    else if (frame_start_i)
    begin
      enq_valid = 1'b1;
      enq_byte  = {~frame_ext_i, 1'b0, frame_norep_i, 1'b1, frame_prio_i, 2'b00};
    end
    else if (bus_valid_i)
    begin
      if (bus_kind_i == `HSIL_EV_ACK)
      begin
        enq_valid = monitor_o;
        enq_byte  = bus_byte_i & `HSIL_ACK_MASK;
      end
      else if (bus_kind_i == `HSIL_EV_FSTAT)
      begin
        enq_valid = 1'b1;
        enq_byte  = {bus_byte_i[7:5], 1'b1, bus_byte_i[3], 3'b011};
      end
      else
      begin
        enq_valid = 1'b1;
        enq_byte  = bus_byte_i;
      end
    end
  end

  // =====================================
  // Outgoing queue toward the host link
  // Absorbs bursts while the host link is slow or stalled
  // Read side pops only when the output flop is empty,
  // so the queue head and the output flop never disagree
  hsil_fifo #(
    .WIDTH (8),
    .DEPTH (`HSIL_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .wdata_i  (enq_byte),
    .wvalid_i (enq_valid),
    .wready_o (fifo_wready),
    .rdata_o  (fifo_rdata),
    .rvalid_o (fifo_rvalid),
    .rready_i (ind_ready_i && !ind_valid_o)
  );

  // =====================================
  // Output stage: flop holds byte until host takes it
  // Valid drops for one cycle after each handoff; this
  // halves peak rate but keeps the handshake trivially safe
  // Overflow is a one-cycle pulse per dropped byte
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ind_byte_o  <= 8'h00;
      ind_valid_o <= 1'b0;
      overflow_o  <= 1'b0;
    end
    else
    begin
      if (ind_valid_o && ind_ready_i)
        ind_valid_o <= 1'b0;
      else if (!ind_valid_o && fifo_rvalid && ind_ready_i)
      begin
        ind_byte_o  <= fifo_rdata;
        ind_valid_o <= 1'b1;
      end
      overflow_o <= enq_valid && !fifo_wready; // Queue full drops byte
    end
  end

  // =====================================
  // Command parser and modes
  // Reset request clears modes and address but not the flags
  // here; flags have their own process below
  // A pending address is applied only while the bus is idle,
  // so an answer in flight never sees a half-changed address
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state             <= S_CMD;
      addr_hi           <= 8'h00;
      pend_addr         <= `HSIL_ADDR_RST;
      pend_valid        <= 1'b0;
      phys_addr_o       <= `HSIL_ADDR_RST;
      auto_ack_active_o <= 1'b0;
      busy_mode_o       <= 1'b0;
      monitor_o         <= 1'b0;
    end
    else if (do_reset)
    begin
      state             <= S_CMD;
      pend_valid        <= 1'b0;
      phys_addr_o       <= `HSIL_ADDR_RST;
      auto_ack_active_o <= 1'b0;
      busy_mode_o       <= 1'b0;
      monitor_o         <= 1'b0;
    end
    else
    begin
      if (host_valid_i)
      begin
        case (state)
          S_CMD:
          begin
            if (host_byte_i == `HSIL_CMD_SET_BUSY && auto_ack_active_o)
              busy_mode_o <= 1'b1;
            else if (host_byte_i == `HSIL_CMD_QUIT_BUSY && auto_ack_active_o)
              busy_mode_o <= 1'b0;
            else if (host_byte_i == `HSIL_CMD_BUSMON)
              monitor_o <= 1'b1;
            else if (host_byte_i == `HSIL_CMD_SET_ADDR)
              state <= S_AH;
          end
          S_AH:
          begin
            addr_hi <= host_byte_i;
            state   <= S_AL;
          end
          S_AL:
          begin
            pend_addr  <= {addr_hi, host_byte_i};
            pend_valid <= 1'b1;
            state      <= S_DUM;
          end
          default:
            state <= S_CMD; // Value ignored
        endcase
      end
      if (host_ack_req_i)
        busy_mode_o <= 1'b0;
      if (pend_valid && bus_idle_i)
      begin
        phys_addr_o       <= pend_addr;
        auto_ack_active_o <= 1'b1;
        pend_valid        <= 1'b0;
      end
    end
  end

  // =====================================
  // Error flags: set wins over reset-request clear
  // Flags are sticky: a one-cycle event is never lost even
  // if the host asks for the state much later
  // Only the reset request clears them
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      slave_collision_flag <= 1'b0;
      receive_error_flag   <= 1'b0;
      transmit_error_flag  <= 1'b0;
      sequence_error_flag  <= 1'b0;
      thermal_warning_flag <= 1'b0;
    end
    else
    begin
      slave_collision_flag <= poll_collision_i | (slave_collision_flag & ~do_reset);
      receive_error_flag   <= host_corrupt_i | (receive_error_flag & ~do_reset);
      transmit_error_flag  <= tx_mismatch_i | (transmit_error_flag & ~do_reset);
      sequence_error_flag  <= seq_error_i | (sequence_error_flag & ~do_reset);
      thermal_warning_flag <= thermal_i | (thermal_warning_flag & ~do_reset);
    end
  end

  // =====================================
  // Automatic bus acknowledge
  // Negative answer wins over busy: a broken frame must be
  // repeated regardless of the busy state
  // Answer is a one-cycle strobe after the answer slot
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bus_ack_o       <= 2'd0;
      bus_ack_valid_o <= 1'b0;
    end
    else
    begin
      bus_ack_valid_o <= 1'b0;
      bus_ack_o       <= 2'd0;
      if (ack_slot_i && auto_ack_active_o && (dst_match_i || dst_group_i))
      begin
        bus_ack_valid_o <= 1'b1;
        if (rx_err_i)
          bus_ack_o <= 2'd2;
        else if (busy_mode_o && dst_match_i)
          bus_ack_o <= 2'd3;
        else
          bus_ack_o <= 2'd1;
      end
    end
  end
endmodule
`default_nettype wire

/* core/hsil_fifo.v */
`timescale 1ns/1ps
`default_nettype none
// =====================================
// Small flop FIFO for indication bytes
module hsil_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_i,   // Clock
  input  wire             arst_n_i,// Async reset
  input  wire [WIDTH-1:0] wdata_i, // Write data
  input  wire             wvalid_i,// Write valid
  output wire             wready_o,// Not full
  output wire [WIDTH-1:0] rdata_o, // Read data
  output wire             rvalid_o,// Not empty
  input  wire             rready_i // Reader takes
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
  reg [AW-1:0]    wptr;            // Write index
  reg [AW-1:0]    rptr;            // Read index
  reg [AW:0]      cnt;             // Fill level
  wire do_w = wvalid_i && wready_o;
  wire do_r = rvalid_o && rready_i;
  assign wready_o = (cnt != DEPTH);
  assign rvalid_o = (cnt != 0);
  assign rdata_o  = mem[rptr];
  // Storage write, no reset needed on data
  always @(posedge clk_i)
  begin
    if (do_w)
      mem[wptr] <= wdata_i;
  end
  // Pointers and level
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      cnt  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_w)
        wptr <= (wptr == DEPTH-1) ? {AW{1'b0}} : wptr + 1'b1;
      if (do_r)
        rptr <= (rptr == DEPTH-1) ? {AW{1'b0}} : rptr + 1'b1;
      if (do_w && !do_r)
        cnt <= cnt + 1'b1;
      else if (do_r && !do_w)
        cnt <= cnt - 1'b1;
    end
  end
endmodule
`default_nettype wire

/* core/hsil_regs.vh */
`ifndef HSIL_REGS_VH
`define HSIL_REGS_VH
// Host command opcodes
`define HSIL_CMD_RESET      8'h01
`define HSIL_CMD_STATE      8'h02
`define HSIL_CMD_SET_BUSY   8'h03
`define HSIL_CMD_QUIT_BUSY  8'h04
`define HSIL_CMD_BUSMON     8'h05
`define HSIL_CMD_SET_ADDR   8'hF1
// Fixed indication codes and patterns
`define HSIL_IND_RESET      8'h03
`define HSIL_CON_LOW        7'h0B
`define HSIL_STATE_LOW      3'h7
`define HSIL_CFG_LOW        2'h1
`define HSIL_ACK_MASK       8'hCC
// Bus event kinds presented to the indication path
`define HSIL_EV_DATA        2'h0
`define HSIL_EV_ACK         2'h1
`define HSIL_EV_FSTAT       2'h2
// Reset values and queue depth
`define HSIL_ADDR_RST       16'h0000
`define HSIL_FIFO_DEPTH     8
`endif

/* verif/hsil_core_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port-level checker for the service core
module hsil_core_chk (
  input wire logic       clk_i,             // Clock
  input wire logic       arst_n_i,          // Async reset
  input wire logic [7:0] host_byte_i,       // Host byte
  input wire logic       host_valid_i,      // Host strobe
  input wire logic       host_ack_req_i,    // Host ack request
  input wire logic       bus_idle_i,        // Bus idle
  input wire logic       dst_match_i,       // Own address
  input wire logic       dst_group_i,       // Group address
  input wire logic       ack_slot_i,        // Answer slot
  input wire logic       rx_err_i,          // Receive error
  input wire logic       ind_ready_i,       // Host takes byte
  input wire logic [7:0] ind_byte_o,        // Indication byte
  input wire logic       ind_valid_o,       // Indication valid
  input wire logic [1:0] bus_ack_o,         // Ack code
  input wire logic       bus_ack_valid_o,   // Ack strobe
  input wire logic       auto_ack_active_o, // Auto-ack state
  input wire logic       busy_mode_o,       // Busy state
  input wire logic       monitor_o          // Monitor state
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Reset command byte; only a reset may clear sticky modes
  wire rst_cmd = host_valid_i && host_byte_i == 8'h01;
  a_ack_busy: assert property (ack_slot_i && auto_ack_active_o && busy_mode_o
    && dst_match_i && !rx_err_i |=> bus_ack_valid_o && bus_ack_o == 2'h3) else $error("no busy");
  a_ack_pos: assert property (ack_slot_i && auto_ack_active_o && !busy_mode_o
    && (dst_match_i || dst_group_i) && !rx_err_i |=> bus_ack_o == 2'h1) else $error("no pos");
  a_ack_neg: assert property (ack_slot_i && auto_ack_active_o && rx_err_i
    && (dst_match_i || dst_group_i) |=> bus_ack_o == 2'h2) else $error("no neg");
  a_ack_none: assert property (ack_slot_i && !auto_ack_active_o
    |=> !bus_ack_valid_o) else $error("ack without auto-ack");
  a_aa_sticky: assert property (auto_ack_active_o && !rst_cmd
    |=> auto_ack_active_o) else $error("auto-ack lost");
  a_mon_sticky: assert property (monitor_o && !rst_cmd
    |=> monitor_o) else $error("monitor lost");
  a_ack_req: assert property (host_ack_req_i |=> !busy_mode_o) else $error("busy kept");
  a_aa_idle: assert property ($rose(auto_ack_active_o) |-> $past(bus_idle_i))
    else $error("auto-ack not at idle");
  a_busy_aa: assert property ($rose(busy_mode_o) |-> auto_ack_active_o)
    else $error("busy without auto-ack");
  a_ind_hold: assert property (ind_valid_o && !ind_ready_i // Byte stands until taken
    |=> ind_valid_o && $stable(ind_byte_o)) else $error("indication dropped");
endmodule
bind hsil_core hsil_core_chk u_chk (.clk_i, .arst_n_i, .host_byte_i, .host_valid_i,
  .host_ack_req_i, .bus_idle_i, .dst_match_i, .dst_group_i, .ack_slot_i, .rx_err_i,
  .ind_ready_i, .ind_byte_o, .ind_valid_o, .bus_ack_o, .bus_ack_valid_o,
  .auto_ack_active_o, .busy_mode_o, .monitor_o);
`default_nettype wire

/* verif/hsil_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module hsil_core_tb;
  // ==========================================
  // Stimulus, all changed at the falling edge
  logic       clk = 1'b0, arst_n = 1'b0, hv = 1'b0, ackq = 1'b0, ne = 1'b0, idle = 1'b1;
  logic       bv = 1'b0, fs = 1'b0, fx = 1'b0, fr = 1'b0, cv = 1'b0, cp = 1'b0, stall = 1'b0;
  logic       dm = 1'b0, dg = 1'b0, sl = 1'b0, re = 1'b0, ov;
  logic [7:0] hb = 8'h00, bb = 8'h00, ex = 8'h07;
  logic [4:0] fl = 5'h00; // Collision, corrupt, mismatch, sequence, thermal
  logic [1:0] bk = 2'h0, fp = 2'h0;
  wire  [7:0] ib;
  wire [15:0] pa;
  wire  [1:0] ack;
  wire        ivld, ird, ackv, aa, busy, mon, ovf;
  int         errors = 0, total_checks = 0, rd = 0;
  always #5 clk = ~clk;
  hsil_core u_dut (.clk_i(clk), .arst_n_i(arst_n), .host_byte_i(hb), .host_valid_i(hv),
    .host_corrupt_i(fl[3]), .host_ack_req_i(ackq), .seq_error_i(fl[1]),
    .poll_collision_i(fl[4]), .tx_mismatch_i(fl[2]), .thermal_i(fl[0]),
    .normal_entry_i(ne), .bus_idle_i(idle), .bus_byte_i(bb), .bus_kind_i(bk),
    .bus_valid_i(bv), .frame_start_i(fs), .frame_ext_i(fx), .frame_norep_i(fr),
    .frame_prio_i(fp), .con_valid_i(cv), .con_pos_i(cp), .dst_match_i(dm),
    .dst_group_i(dg), .ack_slot_i(sl), .rx_err_i(re), .auto_poll_i(1'b1),
    .crc_on_i(1'b1), .marker_on_i(1'b0), .ind_ready_i(ird), .ind_byte_o(ib),
    .ind_valid_o(ivld), .bus_ack_o(ack), .bus_ack_valid_o(ackv), .auto_ack_active_o(aa),
    .busy_mode_o(busy), .monitor_o(mon), .phys_addr_o(pa), .overflow_o(ovf));
  hsil_host_model u_host (.clk_i(clk), .arst_n_i(arst_n), .ind_byte_i(ib),
    .ind_valid_i(ivld), .stall_i(stall), .ind_ready_o(ird));
  // ==========================================
  // Shared tasks
  task stop_test;
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic c);
    total_checks++;
    if (c !== 1'b1)
    begin
      errors++;
      $display("unexpected at %0t: check %0d mismatched", $time, total_checks);
    end
  endtask
  task send(input logic [7:0] b);
    @(negedge clk) {hb, hv} = {b, 1'b1};
    @(negedge clk) hv = 1'b0;
  endtask
  task bus(input logic [1:0] k, input logic [7:0] b);
    @(negedge clk) {bk, bb, bv} = {k, b, 1'b1};
    @(negedge clk) bv = 1'b0;
  endtask
  // Next logged indication, bounded wait so a lost byte cannot hang
  task get(input logic [7:0] e);
    int n;
    n = 0;
    while (u_host.cnt <= rd && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 100)
    begin
      errors++;
      stop_test;
    end
    else
    begin
      chk(u_host.mem[rd[5:0]] === e);
      rd++;
    end
  endtask
  task slot(input logic m, g, e, v, input logic [1:0] x);
    @(negedge clk) {dm, dg, re, sl} = {m, g, e, 1'b1};
    @(negedge clk) sl = 1'b0;
    chk(ackv === v && (!v || ack === x));
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    chk(ivld === 1'b0 && aa === 1'b0 && pa === 16'h0000);
    for (int i = 4; i >= 0; i--)
    begin
      @(negedge clk) fl[i] = 1'b1;
      @(negedge clk) fl = 5'h00;
      send(8'h02);
      ex[i+3] = 1'b1;
      get(ex);
    end
    send(8'h01);
    send(8'h02);
    get(8'h07);
    send(8'h03);
    chk(busy === 1'b0);
    slot(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
    idle = 1'b0;
    send(8'hF1);
    send(8'h12);
    send(8'h34);
    send(8'h01); // Dummy equal to the reset opcode must be ignored
    repeat (4) @(negedge clk) chk(aa === 1'b0);
    idle = 1'b1;
    get(8'h39);
    chk(aa === 1'b1 && pa === 16'h1234);
    slot(1'b1, 1'b0, 1'b0, 1'b1, 2'h1);
    slot(1'b0, 1'b1, 1'b1, 1'b1, 2'h2);
    send(8'h03);
    slot(1'b1, 1'b0, 1'b0, 1'b1, 2'h3);
    @(negedge clk) ackq = 1'b1;
    @(negedge clk) ackq = 1'b0;
    chk(busy === 1'b0);
    send(8'h03);
    send(8'h04);
    slot(1'b1, 1'b0, 1'b0, 1'b1, 2'h1);
    bus(2'h0, 8'h5A);
    get(8'h5A);
    bus(2'h1, 8'hF7);
    @(negedge clk) {fs, fx, fr, fp} = 5'b10110;
    @(negedge clk) {fs, fx, fr, fp} = 5'b11001;
    @(negedge clk) {fs, cv, cp} = 3'b011;
    @(negedge clk) {cv, cp} = 2'b10;
    @(negedge clk) cv = 1'b0;
    get(8'hB8); // Ack byte dropped ahead of it
    get(8'h14);
    get(8'h8B);
    get(8'h0B);
    @(negedge clk) ne = 1'b1;
    @(negedge clk) ne = 1'b0;
    get(8'h03);
    send(8'h05);
    bus(2'h1, 8'hFF);
    get(8'hCC);
    bus(2'h2, 8'hA0);
    get(8'hB3);
    // Fill the queue with the host stalled until it refuses
    stall = 1'b1;
    ov = 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      bus(2'h0, 8'h40 + i[7:0]);
      ov = ov | ovf;
      @(negedge clk) ov = ov | ovf;
    end
    chk(ov === 1'b1);
    stall = 1'b0;
    for (int i = 0; i < 8; i++)
      get(8'h40 + i[7:0]);
    repeat (20) @(negedge clk);
    rd = u_host.cnt;
    send(8'hF1);
    send(8'h56);
    send(8'h78);
    send(8'h00);
    repeat (4) @(negedge clk);
    chk(pa === 16'h5678 && aa === 1'b1 && mon === 1'b1);
    send(8'h01);
    repeat (2) @(negedge clk);
    chk(mon === 1'b0 && aa === 1'b0 && busy === 1'b0);
    stop_test;
  end
endmodule
`default_nettype wire

/* verif/hsil_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host sink: logs every indication byte it takes
module hsil_host_model (
  input  wire logic       clk_i,       // Clock
  input  wire logic       arst_n_i,    // Async reset
  input  wire logic [7:0] ind_byte_i,  // Indication byte
  input  wire logic       ind_valid_i, // Indication valid
  input  wire logic       stall_i,     // Hold off the link
  output wire logic       ind_ready_o  // Link can take
);
  logic [7:0] mem [0:63]; // Log, read by the bench
  int         cnt;        // Bytes logged
  assign ind_ready_o = !stall_i;
  // Take a byte only at an edge with valid and ready
  always @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      cnt <= 0;
    else if (ind_valid_i && ind_ready_o)
    begin
      mem[cnt[5:0]] <= ind_byte_i;
      cnt <= cnt + 1;
    end
endmodule
`default_nettype wire
